//--- rtl/period_timer_pkg.sv
package period_timer_pkg;

   localparam int COUNT_W = 8;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int PRE_CNT_W = 7;
   localparam int PRE_SEL_W = 3;
   localparam int POST_SEL_W = 4;
   localparam int MODE_W = 5;
   localparam int ERS_SEL_W = 8;

   localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_LIMIT_MODE = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_ERS_SELECT = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

   localparam int CTL_RUN_BIT = 7;
   localparam int CTL_PRE_LSB = 4;
   localparam int CTL_POST_LSB = 0;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_MATCH_BIT = 1;
   localparam int STAT_ERS_BIT = 2;

   localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [COUNT_W-1:0] PERIOD_RST = 8'hff;
   localparam logic [PRE_SEL_W-1:0] PRE_SEL_RST = 3'h0;
   localparam logic [POST_SEL_W-1:0] POST_SEL_RST = 4'h0;
   localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
   localparam logic [ERS_SEL_W-1:0] ERS_SEL_RST = 8'h00;

   typedef enum logic [1:0] {
      GRP_FREE = 2'b00,
      GRP_ONESHOT = 2'b01,
      GRP_MIXED = 2'b10,
      GRP_RSVD = 2'b11
   } mode_grp_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } timer_state_t;

endpackage

//--- rtl/ratio_count_if.sv
`timescale 1ns/100ps
interface ratio_count_if #(
   parameter int W = 4
);
   logic step;
   logic clear;
   logic [W-1:0] limit;
   logic hit;
   logic [W-1:0] count;

   modport owner (output step, output clear, output limit, input hit, input count);
   modport counter (input step, input clear, input limit, output hit, output count);
endinterface

//--- rtl/ratio_counter.sv
`timescale 1ns/100ps
module ratio_counter #(
   parameter int W = 4
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   ratio_count_if.counter cnt_if
);
   import period_timer_pkg::*;

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   generate
      if (W < 1 || W > 16) begin : g_bad_w
         $error("ratio_counter width out of range");
      end
   endgenerate

   // The hit is combinational so the owner sees it in the very step that wraps.
   assign cnt_if.hit = cnt_if.step && (cnt_q == cnt_if.limit);
   assign cnt_if.count = cnt_q;

   always_comb begin
      cnt_d = cnt_q;
      if (cnt_if.clear) begin
         cnt_d = '0;
      end else if (cnt_if.step) begin
         if (cnt_q == cnt_if.limit) begin
            cnt_d = '0;
         end else begin
            cnt_d = W'(cnt_q + 1'b1);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
      end
   end
endmodule // ratio_counter

//--- rtl/period_timer_with_hw_limit.sv
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module period_timer_with_hw_limit #(
   parameter int N_EXT = 4
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [period_timer_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [period_timer_pkg::DATA_W-1:0] avs_writedata_i,
   output logic [period_timer_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic timer_tick_clock_i,
   input wire logic [N_EXT-1:0] ext_src_i,
   input wire logic debug_freeze_i,
   output logic [period_timer_pkg::COUNT_W-1:0] count_value_o,
   output logic period_match_o,
   output logic prescaled_tick_o,
   output logic period_event_pulse_o,
   output logic adc_trigger_o,
   output logic shutdown_src_o
);
   import period_timer_pkg::*;

   generate
      if (N_EXT < 1 || N_EXT > 256) begin : g_bad_n_ext
         $error("N_EXT must lie between 1 and 256");
      end
   endgenerate

   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;
   logic [COUNT_W-1:0] period_q;
   logic [COUNT_W-1:0] period_d;
   logic run_enable_q;
   logic run_enable_d;
   logic [PRE_SEL_W-1:0] pre_sel_q;
   logic [PRE_SEL_W-1:0] pre_sel_d;
   logic [POST_SEL_W-1:0] postscale_select_q;
   logic [POST_SEL_W-1:0] postscale_select_d;
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   logic [ERS_SEL_W-1:0] ers_sel_q;
   logic [ERS_SEL_W-1:0] ers_sel_d;
   logic ers_prev_q;
   logic ers_prev_d;
   timer_state_t state_q;
   timer_state_t state_d;
   logic pulse_q;
   logic pulse_d;
   logic match_q;
   logic match_d;
   logic ptick_q;
   logic ptick_d;
   logic ack_q;
   logic ack_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   ratio_count_if #(.W(PRE_CNT_W)) pre_if ();
   ratio_count_if #(.W(POST_SEL_W)) post_if ();

   ratio_counter #(.W(PRE_CNT_W)) u_prescaler (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .cnt_if(pre_if.counter)
   );

   ratio_counter #(.W(POST_SEL_W)) u_postscaler (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .cnt_if(post_if.counter)
   );

   // Bus slave: while ce_i is high, every access costs exactly one wait cycle.
   logic bus_req;
   logic wr_acc;
   logic count_wr;
   logic period_wr;
   logic ctl_wr;
   logic mode_wr;
   logic ers_wr;

   assign bus_req = avs_read_i || avs_write_i;
   assign avs_waitrequest_o = bus_req && !ack_q;
   assign wr_acc = avs_write_i && ack_q && avs_byteenable_i[0];
   assign count_wr = wr_acc && (avs_address_i == OFS_COUNT);
   assign period_wr = wr_acc && (avs_address_i == OFS_PERIOD);
   assign ctl_wr = wr_acc && (avs_address_i == OFS_CONTROL);
   assign mode_wr = wr_acc && (avs_address_i == OFS_LIMIT_MODE);
   assign ers_wr = wr_acc && (avs_address_i == OFS_ERS_SELECT);

   // External source selection and trigger qualification.
   logic ers_raw;
   logic ers_eff;
   logic rise;
   logic fall;
   logic any_edge;

   always_comb begin
      ers_raw = 1'b0;
      for (int i = 0; i < N_EXT; i++) begin
         if (ers_sel_q == ERS_SEL_W'(i)) begin
            ers_raw = ext_src_i[i];
         end
      end
   end

   // Freezing the sampled level hides every edge and keeps each gate where it was.
   assign ers_eff = debug_freeze_i ? ers_prev_q : ers_raw;
   assign rise = timer_tick_clock_i && ers_eff && !ers_prev_q;
   assign fall = timer_tick_clock_i && !ers_eff && ers_prev_q;
   assign any_edge = rise || fall;

   // Mode decode.
   mode_grp_t grp;
   logic [2:0] variant;
   logic valid;
   logic gate;
   logic rst_cond;
   logic start_cond;
   logic is_shot;
   logic clears_run;

   always_comb begin
      grp = mode_grp_t'(mode_q[4:3]);
      variant = mode_q[2:0];
      valid = 1'b1;
      gate = 1'b1;
      rst_cond = 1'b0;
      start_cond = 1'b0;
      is_shot = 1'b0;
      clears_run = 1'b0;
      case (grp)
         GRP_FREE: begin
            case (variant)
               3'h1: gate = ers_eff;
               3'h2: gate = !ers_eff;
               3'h3: rst_cond = any_edge;
               3'h4: rst_cond = rise;
               3'h5: rst_cond = fall;
               3'h6: begin
                  rst_cond = !ers_eff;
                  gate = ers_eff;
               end
               3'h7: begin
                  rst_cond = ers_eff;
                  gate = !ers_eff;
               end
               default: gate = 1'b1;
            endcase
         end
         GRP_ONESHOT: begin
            is_shot = 1'b1;
            clears_run = 1'b1;
            case (variant)
               3'h0: start_cond = 1'b1;
               3'h1: start_cond = rise;
               3'h2: start_cond = fall;
               3'h3: start_cond = any_edge;
               3'h4: begin
                  start_cond = rise;
                  rst_cond = rise;
               end
               3'h5: begin
                  start_cond = fall;
                  rst_cond = fall;
               end
               3'h6: begin
                  start_cond = rise;
                  rst_cond = !ers_eff;
               end
               default: begin
                  start_cond = fall;
                  rst_cond = ers_eff;
               end
            endcase
         end
         GRP_MIXED: begin
            is_shot = 1'b1;
            case (variant)
               3'h1: start_cond = rise;
               3'h2: start_cond = fall;
               3'h3: start_cond = any_edge;
               3'h6: begin
                  clears_run = 1'b1;
                  start_cond = ers_eff;
                  rst_cond = !ers_eff;
               end
               3'h7: begin
                  clears_run = 1'b1;
                  start_cond = !ers_eff;
                  rst_cond = ers_eff;
               end
               default: valid = 1'b0;
            endcase
         end
         default: valid = 1'b0;
      endcase
   end

   // Counting core.
   logic active;
   logic rst_now;
   logic started;
   logic at_match;
   logic post_fire;

   assign rst_now = valid && run_enable_q && rst_cond;
   assign started = is_shot && (state_q == ST_IDLE) && run_enable_q && valid && start_cond;
   assign active = run_enable_q && valid && gate && (!is_shot || state_q == ST_RUN);
   assign at_match = pre_if.hit && !rst_now && (count_q == period_q);
   assign post_fire = at_match && post_if.hit;

   assign pre_if.step = active && timer_tick_clock_i;
   assign pre_if.limit = PRE_CNT_W'((8'h01 << pre_sel_q) - 8'h01);
   assign pre_if.clear = count_wr || ctl_wr || rst_now;
   assign post_if.step = at_match;
   assign post_if.limit = postscale_select_q;
   assign post_if.clear = count_wr || ctl_wr || rst_now || started;

   always_comb begin
      count_d = count_q;
      state_d = state_q;
      run_enable_d = run_enable_q;
      if (!run_enable_q || !valid) begin
         state_d = ST_IDLE;
      end else if (!is_shot) begin
         state_d = ST_RUN;
      end else if (started) begin
         state_d = ST_RUN;
      end
      if (rst_now) begin
         count_d = COUNT_RST;
      end else if (pre_if.hit) begin
         if (count_q == period_q) begin
            count_d = COUNT_RST;
            if (is_shot) begin
               state_d = ST_IDLE;
               if (clears_run) begin
                  run_enable_d = 1'b0;
               end
            end
         end else begin
            count_d = COUNT_W'(count_q + 1'b1);
         end
      end
      if (count_wr) begin
         count_d = avs_writedata_i[COUNT_W-1:0];
      end
      if (ctl_wr) begin
         run_enable_d = avs_writedata_i[CTL_RUN_BIT];
      end
   end

   always_comb begin
      pulse_d = pulse_q;
      if (!run_enable_q) begin
         pulse_d = 1'b0;
      end else if (timer_tick_clock_i) begin
         pulse_d = post_fire;
      end
      match_d = run_enable_q && (count_d == period_d);
      ptick_d = pre_if.hit;
      ers_prev_d = timer_tick_clock_i ? ers_eff : ers_prev_q;
   end

   // Register file.
   always_comb begin
      period_d = period_wr ? avs_writedata_i[COUNT_W-1:0] : period_q;
      pre_sel_d = pre_sel_q;
      postscale_select_d = postscale_select_q;
      mode_d = mode_wr ? avs_writedata_i[MODE_W-1:0] : mode_q;
      ers_sel_d = ers_wr ? avs_writedata_i[ERS_SEL_W-1:0] : ers_sel_q;
      if (ctl_wr) begin
         pre_sel_d = avs_writedata_i[CTL_PRE_LSB +: PRE_SEL_W];
         postscale_select_d = avs_writedata_i[CTL_POST_LSB +: POST_SEL_W];
      end
      ack_d = bus_req && !ack_q;
      rdata_d = rdata_q;
      if (ack_d && avs_read_i) begin
         rdata_d = '0;
         if (avs_address_i == OFS_COUNT) begin
            rdata_d[COUNT_W-1:0] = count_q;
         end else if (avs_address_i == OFS_PERIOD) begin
            rdata_d[COUNT_W-1:0] = period_q;
         end else if (avs_address_i == OFS_CONTROL) begin
            rdata_d[CTL_RUN_BIT] = run_enable_q;
            rdata_d[CTL_PRE_LSB +: PRE_SEL_W] = pre_sel_q;
            rdata_d[CTL_POST_LSB +: POST_SEL_W] = postscale_select_q;
         end else if (avs_address_i == OFS_LIMIT_MODE) begin
            rdata_d[MODE_W-1:0] = mode_q;
         end else if (avs_address_i == OFS_ERS_SELECT) begin
            rdata_d[ERS_SEL_W-1:0] = ers_sel_q;
         end else if (avs_address_i == OFS_STATUS) begin
            rdata_d[STAT_RUN_BIT] = active;
            rdata_d[STAT_MATCH_BIT] = match_q;
            rdata_d[STAT_ERS_BIT] = ers_eff;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_q <= COUNT_RST;
         period_q <= PERIOD_RST;
         run_enable_q <= 1'b0;
         pre_sel_q <= PRE_SEL_RST;
         postscale_select_q <= POST_SEL_RST;
         mode_q <= MODE_RST;
         ers_sel_q <= ERS_SEL_RST;
         ers_prev_q <= 1'b0;
         state_q <= ST_IDLE;
         pulse_q <= 1'b0;
         match_q <= 1'b0;
         ptick_q <= 1'b0;
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else if (ce_i) begin
         count_q <= count_d;
         period_q <= period_d;
         run_enable_q <= run_enable_d;
         pre_sel_q <= pre_sel_d;
         postscale_select_q <= postscale_select_d;
         mode_q <= mode_d;
         ers_sel_q <= ers_sel_d;
         ers_prev_q <= ers_prev_d;
         state_q <= state_d;
         pulse_q <= pulse_d;
         match_q <= match_d;
         ptick_q <= ptick_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign count_value_o = count_q;
   assign period_match_o = match_q;
   assign prescaled_tick_o = ptick_q;
   assign period_event_pulse_o = pulse_q;
   assign adc_trigger_o = pulse_q;
   assign shutdown_src_o = pulse_q;
endmodule // period_timer_with_hw_limit

//--- testbench/period_timer_props.sv
`timescale 1ns/100ps
module period_timer_props (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic timer_tick_clock_i,
   input wire logic [period_timer_pkg::COUNT_W-1:0] count_value_o,
   input wire logic period_match_o,
   input wire logic prescaled_tick_o,
   input wire logic period_event_pulse_o,
   input wire logic adc_trigger_o,
   input wire logic shutdown_src_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_req;
      $rose(avs_read_i || avs_write_i);
   endsequence
   sequence s_ack;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence

   a_wait_once: assert property (s_req |-> s_ack)
      else $error("bus answer not after one wait cycle");
   a_wait_cause: assert property (avs_waitrequest_o |-> avs_read_i || avs_write_i)
      else $error("waitrequest without a request");
   a_adc_copy: assert property (adc_trigger_o == period_event_pulse_o)
      else $error("converter trigger differs from period pulse");
   a_shut_copy: assert property (shutdown_src_o == period_event_pulse_o)
      else $error("shutdown source differs from period pulse");
   a_tick_cause: assert property (prescaled_tick_o |-> $past(timer_tick_clock_i))
      else $error("prescaled tick without a timer tick");
   a_count_step: assert property ($changed(count_value_o) |->
      count_value_o == $past(count_value_o) + 8'h01 || count_value_o == 8'h00
      || $past(avs_write_i) || $past(avs_write_i, 2))
      else $error("count moved by other than one step");
   a_pulse_match: assert property ($rose(period_event_pulse_o) |->
      $past(period_match_o) || $past(period_match_o, 2) || $past(period_match_o, 3))
      else $error("period pulse without a preceding match");
   a_pulse_width: assert property (period_event_pulse_o && $past(period_event_pulse_o)
      |-> !$past(timer_tick_clock_i))
      else $error("period pulse longer than one timer tick");
endmodule // period_timer_props

bind period_timer_with_hw_limit period_timer_props u_props (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .timer_tick_clock_i(timer_tick_clock_i), .count_value_o(count_value_o),
   .period_match_o(period_match_o), .prescaled_tick_o(prescaled_tick_o),
   .period_event_pulse_o(period_event_pulse_o), .adc_trigger_o(adc_trigger_o),
   .shutdown_src_o(shutdown_src_o));

//--- testbench/ext_source_model.sv
`timescale 1ns/100ps
module ext_source_model (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [1:0] tick_div_i,
   input wire logic level_req_i,
   output logic tick_o,
   output logic ers_o
);
   logic [1:0] div_q;
   logic [3:0] gap_q;

   assign tick_o = (div_q == 2'h0);

   // A requested level change waits for seven ticks of quiet, so edges stay far apart
   // and every level outlasts the minimum the timer needs.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q <= 2'h0;
         gap_q <= 4'h0;
         ers_o <= 1'b0;
      end else begin
         div_q <= (div_q >= tick_div_i) ? 2'h0 : div_q + 2'h1;
         if (tick_o && gap_q != 4'hf) gap_q <= gap_q + 4'h1;
         if (ers_o != level_req_i && gap_q >= 4'h7) begin
            ers_o <= level_req_i;
            gap_q <= 4'h0;
         end
      end
   end
endmodule // ext_source_model

//--- testbench/period_timer_with_hw_limit_test.sv
`timescale 1ns/100ps
module period_timer_with_hw_limit_test;
   import period_timer_pkg::*;
   logic clk_sys_i, arst_n_i, rd_q, wr_q, freeze_q, lvl_q, wait_o, tick, ers, ce_q;
   logic match, ptick, pulse, match_d, pulse_d;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata;
   logic [1:0] div_q;
   logic [2:0] ext_hi_q;
   logic [COUNT_W-1:0] cnt;
   logic [DATA_W-1:0] exp_q[$];
   int fails, checks, n_match, n_pulse, m_at, p, s;
   time t_prev, t_last;

   period_timer_with_hw_limit #(.N_EXT(4)) DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .ce_i(ce_q), .avs_address_i(addr_q), .avs_read_i(rd_q), .avs_write_i(wr_q),
      .avs_byteenable_i(4'hf), .avs_writedata_i(wdata_q), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .timer_tick_clock_i(tick), .ext_src_i({ext_hi_q, ers}),
      .debug_freeze_i(freeze_q), .count_value_o(cnt), .period_match_o(match),
      .prescaled_tick_o(ptick), .period_event_pulse_o(pulse), .adc_trigger_o(),
      .shutdown_src_o());

   ext_source_model u_ext (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .tick_div_i(div_q),
      .level_req_i(lvl_q), .tick_o(tick), .ers_o(ers));

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task end_sim;
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_q <= a;
      wdata_q <= d;
      wr_q <= 1'b1;
      do @(posedge clk_sys_i); while (wait_o !== 1'b0);
      wr_q <= 1'b0;
   endtask

   // The expected value is queued first; the watcher below takes it at the answer edge.
   task rd(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys_i);
      addr_q <= a;
      rd_q <= 1'b1;
      do @(posedge clk_sys_i); while (wait_o !== 1'b0);
      rd_q <= 1'b0;
   endtask

   task wait_pulses(input int n);
      while (n_pulse < n) @(posedge clk_sys_i);
   endtask

   always @(posedge clk_sys_i) begin
      if (rd_q === 1'b1 && wait_o === 1'b0) check(rdata, exp_q.pop_front());
      if (match === 1'b1 && match_d !== 1'b1) begin
         n_match++;
         t_prev = t_last;
         t_last = $time;
      end
      if (pulse === 1'b1 && pulse_d !== 1'b1) begin
         n_pulse++;
         if (n_pulse == 2) m_at = n_match;
      end
      match_d = match;
      pulse_d = pulse;
      ext_hi_q <= 3'($urandom);
   end

   initial begin
      repeat (99000) @(posedge clk_sys_i);
      fails++;
      end_sim();
   end

   initial begin
      {rd_q, wr_q, freeze_q, lvl_q, arst_n_i} = '0;
      ce_q = 1'b1;
      addr_q = '0;
      wdata_q = '0;
      div_q = 2'h0;
      ext_hi_q = 3'h0;
      void'($urandom(32'hf408));
      repeat (12) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      rd(OFS_COUNT, 32'h0);
      rd(OFS_PERIOD, 32'hff);
      wr(5'h18, $urandom);
      rd(5'h18, 32'h0);
      p = $urandom;
      wr(OFS_PERIOD, p);
      rd(OFS_PERIOD, {24'h0, p[7:0]});
      wr(OFS_COUNT, p + 3);
      wr(OFS_CONTROL, 32'h35);
      repeat (20) @(posedge clk_sys_i);
      rd(OFS_COUNT, {24'h0, 8'(p + 3)});
      // Each prescale setting runs free with a random period, postscale and tick rate.
      for (int pre = 0; pre < 8; pre++) begin
         p = 4 + $urandom % 4;
         s = $urandom % 4;
         div_q <= 2'($urandom % 2);
         wr(OFS_PERIOD, p);
         wr(OFS_COUNT, 0);
         n_match = 0;
         n_pulse = 0;
         wr(OFS_CONTROL, 32'h80 | (pre << 4) | s);
         wait_pulses(2);
         wr(OFS_CONTROL, 0);
         check(m_at, 2 * (s + 1));
         check(32'((t_last - t_prev) / 50), ((p + 1) << pre) * (div_q + 1));
      end
      div_q <= 2'h0;
      wr(OFS_LIMIT_MODE, 32'h08);
      wr(OFS_COUNT, 0);
      n_pulse = 0;
      wr(OFS_CONTROL, 32'h80);
      wait_pulses(1);
      repeat (60) @(posedge clk_sys_i);
      rd(OFS_CONTROL, 32'h0);
      check(n_pulse, 1);
      wr(OFS_CONTROL, 32'h80);
      wait_pulses(2);
      wr(OFS_CONTROL, 32'h81);
      repeat (60) @(posedge clk_sys_i);
      check(n_pulse, 2);
      wr(OFS_LIMIT_MODE, 32'h11);
      wr(OFS_ERS_SELECT, 0);
      wr(OFS_CONTROL, 32'h80);
      n_pulse = 0;
      lvl_q <= 1'b1;
      wait_pulses(1);
      rd(OFS_CONTROL, 32'h80);
      lvl_q <= 1'b0;
      repeat (40) @(posedge clk_sys_i);
      check(n_pulse, 1);
      lvl_q <= 1'b1;
      wait_pulses(2);
      lvl_q <= 1'b0;
      wr(OFS_CONTROL, 0);
      wr(OFS_LIMIT_MODE, 32'h01);
      repeat (40) @(posedge clk_sys_i);
      wr(OFS_COUNT, 0);
      wr(OFS_CONTROL, 32'h80);
      repeat (20) @(posedge clk_sys_i);
      rd(OFS_COUNT, 32'h0);
      freeze_q <= 1'b1;
      lvl_q <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      rd(OFS_COUNT, 32'h0);
      freeze_q <= 1'b0;
      n_pulse = 0;
      wait_pulses(2);
      // With the clock enable low nothing may move; eleven cycles make more than a whole period of five to eight cycles.
      ce_q <= 1'b0;
      @(posedge clk_sys_i);
      p = cnt;
      repeat (11) @(posedge clk_sys_i);
      check(cnt, p[7:0]);
      ce_q <= 1'b1;
      wr(OFS_PERIOD, 32'hff);
      wr(OFS_LIMIT_MODE, 32'h07);
      wr(OFS_COUNT, 32'h5a);
      wr(OFS_CONTROL, 32'h80);
      repeat (30) @(posedge clk_sys_i);
      rd(OFS_COUNT, 32'h0);
      repeat (4) @(posedge clk_sys_i);
      end_sim();
   end
endmodule // period_timer_with_hw_limit_test
